// *** supply_thermal_map.svh ***
// Register map constants for the supply and thermal status bank
`ifndef SUPPLY_THERMAL_MAP_SVH
`define SUPPLY_THERMAL_MAP_SVH

// Register addresses (7-bit serial address space)
`define SUP_B_ADDR       7'h40
`define SUP_A_ADDR       7'h41
`define THERM_ADDR       7'h42

// Secondary supply status field positions
`define SUP_B_BATT_UV    6
`define SUP_B_R3_OC      4
`define SUP_B_R3_UV      3
`define SUP_B_R3_OT      2
`define SUP_B_MAIN_OV    1
`define SUP_B_MAIN_WARN  0
`define SUP_B_MASK       8'h5F

// Primary supply status field positions
`define SUP_A_POR        7
`define SUP_A_HS_UV      6
`define SUP_A_HS_OV      5
`define SUP_A_R2_OT      4
`define SUP_A_R2_UV      3
`define SUP_A_MAIN_SC    2
`define SUP_A_FS_UV      1
`define SUP_A_MAIN_UV    0

// Thermal status field positions
`define THERM_THERMAL_SHUTDOWN_STAGE2_FLAG       2
`define THERM_THERMAL_SHUTDOWN_STAGE1_FLAG       1
`define THERM_TPW        0
`define THERM_MASK       8'h07

// Reset values
`define SUP_B_RST        8'h00
`define SUP_A_POR_RST    8'h80
`define SUP_A_SOFT_RST   8'h00
`define THERM_RST        8'h00

// Short-to-ground qualification time
`define SHORT_TIME_NS    4000000
`define CLK_PERIOD_NS    4
`define SHORT_CYCLES     (`SHORT_TIME_NS / `CLK_PERIOD_NS)

`endif

// *** supply_thermal_pkg.sv ***
// Types shared by the supply and thermal status bank
package supply_thermal_pkg;

  // Device operating modes as seen by the status bank
  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE
  } dev_mode_t;

  // Raw fault detector events, one per flag source
  typedef struct packed {
    logic batt_uv;
    logic r3_oc;
    logic r3_uv;
    logic r3_ot;
    logic main_ov;
    logic main_warn;
    logic hs_uv;
    logic hs_ov;
    logic r2_ot;
    logic r2_uv;
    logic main_uv;
    logic uv_fourth;
    logic thermal_shutdown_stage2_flag;
    logic thermal_shutdown_stage1_flag;
    logic thermal_prewarn_flag;
  } fault_events_t;

  // Serial command after byte decoding
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic       clear;
  } status_cmd_t;

endpackage

// *** supply_thermal_status_regs.sv ***
// Sticky supply and thermal fault status registers with read and clear
`timescale 1ns/1ns
`include "supply_thermal_map.svh"

// How it works
// R1: Reserved status bits always read zero
// R2: Battery undervoltage latches secondary bit six
// R3: Third regulator faults latch bits four to two
// R4: Main overvolt and prewarning latch bits one, zero
// R5: Power-on sets bit seven; soft reset clears
// R6: High-side under/overvoltage latch bits six, five
// R7: Second regulator overtemp, undervolt latch bits four, three
// R8: Main output low beyond 4ms flags short
// R9: Fourth undervoltage fail-safe entry latches bit one
// R10: Main regulator undervoltage reset latches bit zero
// R11: Sleep with main regulator off blocks main overvolt, short and undervolt flags
// R12: Main undervolt update gated by device mode
// R13: Stage-two shutdown latches and forces fail-safe
// R14: Stage-one shutdown and prewarning latch bits
// R15: Thermal flags never self-clear
// R16: Restart keeps secondary flags, zeroes reserved
// R17: Restart clears only fail-safe undervolt flag
// R18: Restart keeps thermal flags; resets clear all
// R19: Command bit seven low reads, high clears byte
// R20: Flags drop only by clear, reset or restart entry
// R21: Persisting fault sets flag again after clear
module supply_thermal_status_regs
  import supply_thermal_pkg::*;
#(
  parameter int unsigned SHORT_CYCLES = `SHORT_CYCLES
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          soft_reset,
  input  wire dev_mode_t     dev_mode,
  input  wire logic          main_reg_on,
  input  wire logic          reset_output,
  input  wire fault_events_t events,
  input  wire logic          main_below_reset,
  input  wire status_cmd_t   cmd,
  output logic [7:0]         rd_data,
  output logic               rd_valid,
  output logic               failsafe_req
);

  // Elaboration check: the short counter needs at least one cycle
  if (SHORT_CYCLES < 1) begin : g_bad_short
    $error("SHORT_CYCLES must be at least one");
  end

  // Counter saturates one above the limit, so it needs room for SHORT_CYCLES + 1
  localparam int CW = $clog2(SHORT_CYCLES + 2);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [7:0]  sup_b;        // Secondary supply status
    logic [7:0]  sup_a;        // Primary supply status
    logic [7:0]  therm;        // Thermal status
    logic [CW-1:0] sc_cnt;     // Time spent below reset threshold
    logic        ro_seen;      // Reset output released once in init
    logic        restart_prev; // Previous cycle was restart
    logic [7:0]  rd_data;      // Read answer
    logic        rd_valid;     // Read answer strobe
    logic        failsafe;     // Fail-safe request
  } state_t;

  state_t s_q;  // Registered state
  state_t s_d;  // Next state

  logic restart_entry;   // First cycle of restart
  logic main_gate;       // Main regulator flags may set
  logic uv_update;       // Main undervolt may update
  logic sc_now;          // Short condition present
  logic clr_b;           // Clear strobes per register
  logic clr_a;
  logic clr_t;
  logic [7:0] set_b;     // Set vectors per register
  logic [7:0] set_a;
  logic [7:0] set_t;

  // ==========================================================
  // Next state logic
  // ==========================================================
  always_comb begin
    s_d = s_q;
    restart_entry = (dev_mode == MODE_RESTART) && !s_q.restart_prev;
    s_d.restart_prev = (dev_mode == MODE_RESTART);
    // Main regulator flags are meaningless while it is off in sleep
    main_gate = !((dev_mode == MODE_SLEEP) && !main_reg_on);  // R11

    // Short timer counts cycles spent under the reset threshold
    if (main_below_reset && main_gate) begin
      if (s_q.sc_cnt <= CW'(SHORT_CYCLES)) begin
        s_d.sc_cnt = s_q.sc_cnt + CW'(1);
      end
    end else begin
      s_d.sc_cnt = '0;
    end
    sc_now = (s_q.sc_cnt > CW'(SHORT_CYCLES));  // R8

    // Track first release of reset output during init
    if (dev_mode == MODE_INIT && reset_output) begin
      s_d.ro_seen = 1'b1;
    end

    // Undervolt update depends on mode; short overrides every mode except sleep with main regulator off
    unique case (dev_mode)
      MODE_RESTART: uv_update = 1'b0;                        // R12
      MODE_INIT:    uv_update = s_q.ro_seen;                 // R12
      MODE_NORMAL,
      MODE_STOP:    uv_update = 1'b1;                        // R12
      default:      uv_update = 1'b1;
    endcase
    uv_update = (uv_update || sc_now) && main_gate;          // R12

    // Set vectors; a detector that stays active re-sets after clear
    set_b = '0;
    set_b[`SUP_B_BATT_UV]   = events.batt_uv;                // R2
    set_b[`SUP_B_R3_OC]     = events.r3_oc;                  // R3
    set_b[`SUP_B_R3_UV]     = events.r3_uv;                  // R3
    set_b[`SUP_B_R3_OT]     = events.r3_ot;                  // R3
    set_b[`SUP_B_MAIN_OV]   = events.main_ov && main_gate;   // R4
    set_b[`SUP_B_MAIN_WARN] = events.main_warn;              // R4
    set_a = '0;
    set_a[`SUP_A_HS_UV]     = events.hs_uv;                  // R6
    set_a[`SUP_A_HS_OV]     = events.hs_ov;                  // R6
    set_a[`SUP_A_R2_OT]     = events.r2_ot;                  // R7
    set_a[`SUP_A_R2_UV]     = events.r2_uv;                  // R7
    // A count left over from before sleep must not raise the short flag there
    set_a[`SUP_A_MAIN_SC]   = sc_now && main_gate;           // R8 R11
    set_a[`SUP_A_FS_UV]     = events.uv_fourth;              // R9
    set_a[`SUP_A_MAIN_UV]   = events.main_uv && uv_update;   // R10
    set_t = '0;
    set_t[`THERM_THERMAL_SHUTDOWN_STAGE2_FLAG]      = events.thermal_shutdown_stage2_flag;                   // R13
    set_t[`THERM_THERMAL_SHUTDOWN_STAGE1_FLAG]      = events.thermal_shutdown_stage1_flag;                   // R14
    set_t[`THERM_TPW]       = events.thermal_prewarn_flag;                    // R14

    // Command decode: bit seven high clears the addressed byte
    clr_b = cmd.valid && cmd.clear && (cmd.addr == `SUP_B_ADDR);  // R19
    clr_a = cmd.valid && cmd.clear && (cmd.addr == `SUP_A_ADDR);  // R19
    clr_t = cmd.valid && cmd.clear && (cmd.addr == `THERM_ADDR);  // R19

    // Sticky update: set beats a same-cycle clear; restart entry and soft reset below are the only other clears
    s_d.sup_b = ((clr_b ? 8'h00 : s_q.sup_b) | set_b) & `SUP_B_MASK;  // R20 R21 R1
    s_d.sup_a = (clr_a ? 8'h00 : s_q.sup_a) | set_a;                  // R20 R21
    s_d.therm = ((clr_t ? 8'h00 : s_q.therm) | set_t) & `THERM_MASK;  // R15 R21 R1

    // Restart entry: only the fail-safe undervolt flag is dropped
    if (restart_entry) begin
      s_d.sup_b = s_d.sup_b & `SUP_B_MASK;                   // R16
      s_d.sup_a[`SUP_A_FS_UV] = set_a[`SUP_A_FS_UV];         // R17
      s_d.therm = s_d.therm & `THERM_MASK;                   // R18
    end

    // Read answer: whole byte returned, then cleared if asked
    s_d.rd_valid = cmd.valid;                                // R19
    unique case (cmd.addr)
      `SUP_B_ADDR: s_d.rd_data = s_q.sup_b;
      `SUP_A_ADDR: s_d.rd_data = s_q.sup_a;
      `THERM_ADDR: s_d.rd_data = s_q.therm;
      default:     s_d.rd_data = 8'h00;
    endcase
    if (!cmd.valid) begin
      s_d.rd_data = s_q.rd_data;
    end

    // Stage-two shutdown forces fail-safe
    s_d.failsafe = events.thermal_shutdown_stage2_flag;                              // R13

    // Soft reset clears all three status bytes, the short timer and the init tracker, including the power-on flag
    if (soft_reset) begin
      s_d.sup_b   = `SUP_B_RST;                              // R5
      s_d.sup_a   = `SUP_A_SOFT_RST;                         // R5
      s_d.therm   = `THERM_RST;                              // R18
      s_d.ro_seen = 1'b0;
      s_d.sc_cnt  = '0;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q              <= '0;
      s_q.sup_a        <= `SUP_A_POR_RST;                    // R5
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from flip-flops
  assign rd_data      = s_q.rd_data;
  assign rd_valid     = s_q.rd_valid;
  assign failsafe_req = s_q.failsafe;

  // ==========================================================
  // Assertions
  // ==========================================================
  reserved_b_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
    (s_q.sup_b & ~`SUP_B_MASK) == 8'h00 && (s_q.therm & ~`THERM_MASK) == 8'h00)
    else $error("reserved status bit set");

  batt_uv_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
    events.batt_uv && !soft_reset |=> s_q.sup_b[`SUP_B_BATT_UV])
    else $error("battery undervolt not latched");

  short_timer_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
    s_q.sup_a[`SUP_A_MAIN_SC] && !$past(s_q.sup_a[`SUP_A_MAIN_SC]) && !$past(soft_reset)
    |-> $past(s_q.sc_cnt) > CW'(SHORT_CYCLES))
    else $error("short flag without timeout");

  sleep_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
    dev_mode == MODE_SLEEP && !main_reg_on && !s_q.sup_b[`SUP_B_MAIN_OV] && !soft_reset
    |=> !s_q.sup_b[`SUP_B_MAIN_OV])
    else $error("main overvolt set in sleep");

  restart_uv_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
    dev_mode == MODE_RESTART && s_q.sc_cnt == '0 && !s_q.sup_a[0] && !main_below_reset
    |=> !s_q.sup_a[`SUP_A_MAIN_UV])
    else $error("undervolt updated in restart");

  thermal_shutdown_stage2_flag_failsafe_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
    events.thermal_shutdown_stage2_flag |=> failsafe_req && ($past(soft_reset) || s_q.therm[`THERM_THERMAL_SHUTDOWN_STAGE2_FLAG]))
    else $error("stage two shutdown not handled");

  thermal_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
    s_q.therm[`THERM_THERMAL_SHUTDOWN_STAGE1_FLAG] && !soft_reset && !clr_t |=> s_q.therm[`THERM_THERMAL_SHUTDOWN_STAGE1_FLAG])
    else $error("thermal flag self-cleared");

  restart_fs_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
    restart_entry && !events.uv_fourth && !soft_reset && !clr_a
    |=> !s_q.sup_a[`SUP_A_FS_UV] && s_q.sup_a[7] == $past(s_q.sup_a[7]))
    else $error("restart entry handled wrong");

  clear_byte_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R19
    clr_a && set_a == 8'h00 && !soft_reset |=> s_q.sup_a == 8'h00 ##1 1'b1)
    else $error("byte clear failed");

  set_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R21
    clr_b && set_b != 8'h00 && !soft_reset |=> (s_q.sup_b & $past(set_b)) == $past(set_b))
    else $error("set lost against clear");

  // ==========================================================
  // Per-flag latching and hold checks
  // ==========================================================
  // Each check below except soft_clear_a waives the soft reset cycle, which overrides every set

  // Third regulator events show up at the next edge
  r3_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
    !soft_reset |=> (s_q.sup_b[`SUP_B_R3_OC:`SUP_B_R3_OT]
      & $past({events.r3_oc, events.r3_uv, events.r3_ot}))
      == $past({events.r3_oc, events.r3_uv, events.r3_ot}))
    else $error("third regulator flag not latched");

  // Overvoltage only counts while the main regulator flags are enabled
  main_ov_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
    events.main_ov && main_gate && !soft_reset |=> s_q.sup_b[`SUP_B_MAIN_OV])
    else $error("main overvolt not latched");

  // Prewarning has its own fixed threshold and no mode gating
  prewarn_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
    events.main_warn && !soft_reset |=> s_q.sup_b[`SUP_B_MAIN_WARN])
    else $error("prewarning not latched");

  // High-side supply under and overvoltage
  hs_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
    !soft_reset |=> (s_q.sup_a[`SUP_A_HS_UV:`SUP_A_HS_OV] & $past({events.hs_uv, events.hs_ov}))
      == $past({events.hs_uv, events.hs_ov}))
    else $error("high-side flag not latched");

  // Second regulator overtemperature and undervoltage
  r2_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
    !soft_reset |=> (s_q.sup_a[`SUP_A_R2_OT:`SUP_A_R2_UV] & $past({events.r2_ot, events.r2_uv}))
      == $past({events.r2_ot, events.r2_uv}))
    else $error("second regulator flag not latched");

  // Timer expiry must reach the short flag
  short_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
    sc_now && main_gate && !soft_reset |=> s_q.sup_a[`SUP_A_MAIN_SC])
    else $error("short flag not latched");

  // Sleep with the main regulator off never raises the short flag
  sleep_short_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
    dev_mode == MODE_SLEEP && !main_reg_on && !s_q.sup_a[`SUP_A_MAIN_SC] && !soft_reset
    |=> !s_q.sup_a[`SUP_A_MAIN_SC])
    else $error("short flag set in sleep");

  // Fail-safe entry flag, also when it coincides with restart entry
  fs_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
    events.uv_fourth && !soft_reset |=> s_q.sup_a[`SUP_A_FS_UV])
    else $error("fail-safe undervolt not latched");

  // Undervoltage latches whenever the mode gate lets it update
  main_uv_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    events.main_uv && uv_update && !soft_reset |=> s_q.sup_a[`SUP_A_MAIN_UV])
    else $error("main undervolt not latched");

  // Stage-one shutdown and prewarning
  tsd_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
    !soft_reset |=> (s_q.therm[`THERM_THERMAL_SHUTDOWN_STAGE1_FLAG:`THERM_TPW] & $past({events.thermal_shutdown_stage1_flag, events.thermal_prewarn_flag}))
      == $past({events.thermal_shutdown_stage1_flag, events.thermal_prewarn_flag}))
    else $error("thermal flag not latched");

  // Soft reset wipes all three registers, power-on bit included
  soft_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5 R18
    soft_reset |=> s_q.sup_a == 8'h00 && s_q.sup_b == 8'h00 && s_q.therm == 8'h00)
    else $error("soft reset left a flag");

  // Without clear, reset or restart entry no primary bit may drop
  sup_a_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R20
    !soft_reset && !clr_a && !restart_entry
    |=> (s_q.sup_a & $past(s_q.sup_a)) == $past(s_q.sup_a))
    else $error("primary flag dropped");

  // Secondary flags survive everything but a clear or soft reset, restart included
  sup_b_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R16 R20
    !soft_reset && !clr_b |=> (s_q.sup_b & $past(s_q.sup_b)) == $past(s_q.sup_b))
    else $error("secondary flag dropped");

  // Thermal flags survive restart and a vanished condition
  therm_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15 R18
    !soft_reset && !clr_t |=> (s_q.therm & $past(s_q.therm)) == $past(s_q.therm))
    else $error("thermal flag dropped");

  // ==========================================================
  // Read answer checks
  // ==========================================================
  // One answer strobe per command, exactly one cycle later
  read_strobe_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R19
    1'b1 |=> rd_valid == $past(cmd.valid))
    else $error("read strobe mismatch");

  // The answer is the byte as it stood before any clear
  read_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R19
    cmd.valid && cmd.addr == `SUP_A_ADDR |=> rd_data == $past(s_q.sup_a))
    else $error("read data mismatch");

  // Addresses outside the bank answer zero
  unmapped_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
    cmd.valid && cmd.addr != `SUP_A_ADDR && cmd.addr != `SUP_B_ADDR
    && cmd.addr != `THERM_ADDR |=> rd_data == 8'h00)
    else $error("unmapped read not zero");

endmodule

// *** host_model.sv ***
// Host model that issues decoded read and clear commands to the status bank
`timescale 1ns/1ns
module host_model
  import supply_thermal_pkg::*;
(
  input  wire logic  sys_clk,
  output status_cmd_t cmd
);
  // ==========
  // Command driver
  // Idle until the first command
  initial cmd = '0;
  // Caller sits at a falling edge; the command stands one whole cycle
  task automatic send(input logic [6:0] a, input logic c);
    cmd = '{valid: 1'b1, addr: a, clear: c};
    @(negedge sys_clk);
  endtask
  // Drop valid after a burst so no stray command is taken
  task automatic stop();
    cmd.valid = 1'b0;
    @(negedge sys_clk);
  endtask
endmodule

// *** test_supply_thermal_status_regs.sv ***
// Self-checking bench for the supply and thermal status bank
`timescale 1ns/1ns
`include "supply_thermal_map.svh"
module test_supply_thermal_status_regs
  import supply_thermal_pkg::*;
;
  // ==========
  // Signals
  localparam int SC = 8;        // Short count kept small for a fast run
  localparam logic [7:0] MSK [15] = '{8'h01, 8'h02, 8'h04, 8'h02, 8'h01, 8'h08, 8'h10,
    8'h20, 8'h40, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40};
  logic          sys_clk, rst_n, soft_reset, main_reg_on, reset_output, main_below_reset;
  dev_mode_t     dev_mode;
  fault_events_t events;
  status_cmd_t   cmd;
  logic [7:0]    rd_data;
  logic          rd_valid, failsafe_req;
  logic [7:0]    exp_q [$];     // Expected read bytes, oldest first
  int            n_fail = 0;
  int            n_compared = 0;

  supply_thermal_status_regs #(.SHORT_CYCLES(SC)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .soft_reset(soft_reset), .dev_mode(dev_mode), .main_reg_on(main_reg_on),
    .reset_output(reset_output), .events(events), .main_below_reset(main_below_reset),
    .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid), .failsafe_req(failsafe_req));
  host_model i_host (.sys_clk(sys_clk), .cmd(cmd));

  // ==========
  // Clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #(4 * 5000);
    n_fail++;
    end_sim();
  end

  // ==========
  // Checking
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Read answers are settled by the falling edge
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("spare rd_valid", 8'h00, 8'h01);
      else check("rd_data", exp_q.pop_front(), rd_data);
    end
  end
  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========
  // Stimulus helpers
  task automatic rd(input logic [6:0] a, input logic c, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.send(a, c);
  endtask
  // Back to back read, read-clear, read: sticky value twice, then zero
  task automatic rcr(input logic [6:0] a, input logic [7:0] e);
    rd(a, 1'b0, e);
    rd(a, 1'b1, e);
    rd(a, 1'b0, 8'h00);
    i_host.stop();
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // ==========
  // Tests
  initial begin
    void'($urandom(42539));
    {rst_n, soft_reset, main_below_reset} = 3'b000;
    {main_reg_on, reset_output} = 2'b11;
    dev_mode = MODE_NORMAL;
    events = '0;
    tick(3);
    rst_n = 1'b1;
    rcr(`SUP_A_ADDR, 8'h80);
    rcr(`SUP_B_ADDR, 8'h00);
    rcr(`THERM_ADDR, 8'h00);
    $display("test reset values done");
    // Each detector alone, random length, then its one flag bit
    for (int i = 0; i < 15; i++) begin
      events = fault_events_t'(15'h0001 << i);
      tick(1 + $urandom % 3);
      check("failsafe_req", {7'h00, i == 2}, {7'h00, failsafe_req});
      events = '0;
      tick(1);
      rcr(i < 3 ? `THERM_ADDR : i < 9 ? `SUP_A_ADDR : `SUP_B_ADDR, MSK[i]);
    end
    rd(7'h43 + 7'($urandom % 61), 1'($urandom), 8'h00);
    i_host.stop();
    $display("test flag map done");
    // Clear while the fault persists keeps the flag
    events.r3_uv = 1'b1;
    tick(1);
    rd(`SUP_B_ADDR, 1'b1, 8'h08);
    rd(`SUP_B_ADDR, 1'b0, 8'h08);
    i_host.stop();
    events = '0;
    rcr(`SUP_B_ADDR, 8'h08);
    $display("test persisting fault done");
    // Low output for exactly the limit, then well past it
    main_below_reset = 1'b1;
    tick(SC);
    main_below_reset = 1'b0;
    tick(1);
    rcr(`SUP_A_ADDR, 8'h00);
    main_below_reset = 1'b1;
    tick(SC + 4);
    main_below_reset = 1'b0;
    tick(1);
    rcr(`SUP_A_ADDR, 8'h04);
    $display("test short done");
    // Sleep with the main regulator off blocks its overvolt, undervolt and short flags only
    dev_mode = MODE_SLEEP;
    main_reg_on = 1'b0;
    {events.main_ov, events.main_uv, events.batt_uv, main_below_reset} = 4'hF;
    tick(SC + 4);
    {events, main_below_reset} = '0;
    tick(1);
    rcr(`SUP_B_ADDR, 8'h40);
    rcr(`SUP_A_ADDR, 8'h00);
    $display("test sleep done");
    // Restart entry, with undervoltage that must be ignored there
    {dev_mode, main_reg_on} = {MODE_NORMAL, 1'b1};
    {events.uv_fourth, events.hs_uv, events.thermal_shutdown_stage1_flag, events.r3_oc} = 4'hF;
    tick(1);
    events = '0;
    tick(1);
    dev_mode = MODE_RESTART;
    events.main_uv = 1'b1;
    tick(3);
    events = '0;
    tick(1);
    rd(`SUP_A_ADDR, 1'b0, 8'h40);
    rd(`SUP_B_ADDR, 1'b0, 8'h10);
    rd(`THERM_ADDR, 1'b0, 8'h02);
    i_host.stop();
    // Soft reset wipes all three; the power-on bit was already cleared by the first read-clear
    soft_reset = 1'b1;
    tick(1);
    soft_reset = 1'b0;
    tick(1);
    rd(`SUP_A_ADDR, 1'b0, 8'h00);
    rd(`SUP_B_ADDR, 1'b0, 8'h00);
    rd(`THERM_ADDR, 1'b0, 8'h00);
    i_host.stop();
    $display("test restart and soft reset done");
    // Init ignores undervoltage until the reset output was released
    {dev_mode, reset_output} = {MODE_INIT, 1'b0};
    events.main_uv = 1'b1;
    tick(1);
    events = '0;
    tick(1);
    rcr(`SUP_A_ADDR, 8'h00);
    reset_output = 1'b1;
    tick(1);
    reset_output = 1'b0;
    events.main_uv = 1'b1;
    tick(1);
    events = '0;
    tick(1);
    rcr(`SUP_A_ADDR, 8'h01);
    $display("test init gating done");
    check("pending reads", 8'h00, 8'(exp_q.size()));
    end_sim();
  end
endmodule
